// >>> hdl/sitp_target.sv
`timescale 1ns/10ps
`default_nettype none

module sitp_target #(
   parameter int WDT_SHORT_CYCLES = sitp_pkg::SITP_WDT_SHORT_CYC,
   parameter int WDT_LONG_CYCLES  = sitp_pkg::SITP_WDT_LONG_CYC
) (
   input  wire logic                      clk_sys_in,
   input  wire logic                      rst_n_in,
   input  wire logic                      serial_clock_pin_in,
   input  wire logic                      serial_data_pin_in,
   output logic                           serial_data_pin_out,
   output logic                           serial_data_pin_oe_out,
   input  wire logic                      address_select_pin_in,
   input  wire logic                      wdt_enable_in,
   input  wire logic                      wdt_long_period_in,
   input  wire logic [7:0]                reg_rdata_in,
   output sitp_pkg::sitp_access_type      reg_access_out,
   output logic                           bus_busy_out,
   output logic                           wdt_timeout_out
);
   import sitp_pkg::*;

   localparam int WDT_W = $clog2(WDT_LONG_CYCLES + 1);

   // ------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------
   // bit 0 clock, bit 1 data, bit 2 address strap
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [1:0] prev_reg;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
         prev_reg  <= 2'h3;
      end else begin
         sync1_reg <= {address_select_pin_in, serial_data_pin_in,
                       serial_clock_pin_in};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg[1:0];
      end
   end

   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   logic [6:0] own_addr;

   always_comb begin
      scl        = sync2_reg[0];
      sda        = sync2_reg[1];
      scl_rise   = scl & ~prev_reg[0];
      scl_fall   = ~scl & prev_reg[0];
      start_cond = scl & prev_reg[0] & prev_reg[1] & ~sda;
      stop_cond  = scl & prev_reg[0] & ~prev_reg[1] & sda;
      // strap is sampled continuously; it is tied, so no glitch hazard
      own_addr   = sync2_reg[2] ? SITP_ADDR_STRAP_HIGH
                                : SITP_ADDR_STRAP_LOW;
   end

   // ------------------------------------------------------------
   // protocol state
   // ------------------------------------------------------------
   sitp_state_type  state_reg,    state_next;
   logic [2:0]      bitcnt_reg,   bitcnt_next;
   logic            done_reg,     done_next;
   logic [7:0]      shift_reg,    shift_next;
   logic [7:0]      addr_reg,     addr_next;
   logic [7:0]      base_reg,     base_next;
   logic            rw_reg,       rw_next;
   logic            mack_reg,     mack_next;
   logic            fell_reg,     fell_next;
   logic            busy_reg,     busy_next;
   logic            drive_reg,    drive_next;
   logic            write_reg,    write_next;
   logic            read_reg,     read_next;
   logic [7:0]      wdata_reg,    wdata_next;
   logic [WDT_W-1:0] wdt_cnt_reg, wdt_cnt_next;
   logic            wdt_hit_reg,  wdt_hit_next;
   logic [WDT_W-1:0] wdt_limit;
   logic            wdt_fire;

   always_comb begin
      state_next   = state_reg;
      bitcnt_next  = bitcnt_reg;
      done_next    = done_reg;
      shift_next   = shift_reg;
      addr_next    = addr_reg;
      base_next    = base_reg;
      rw_next      = rw_reg;
      mack_next    = mack_reg;
      fell_next    = fell_reg;
      busy_next    = busy_reg;
      drive_next   = drive_reg;
      write_next   = 1'b0;
      read_next    = 1'b0;
      wdata_next   = wdata_reg;

      // ---------------------------------------------------------
      // lock-up watchdog
      // ---------------------------------------------------------
      wdt_limit = wdt_long_period_in ? WDT_W'(WDT_LONG_CYCLES - 1)
                                     : WDT_W'(WDT_SHORT_CYCLES - 1);
      // only a line held low by us counts; any clock edge is progress
      if (!wdt_enable_in || !drive_reg || scl_rise || scl_fall) begin
         wdt_cnt_next = '0;
      end else begin
         wdt_cnt_next = wdt_cnt_reg + WDT_W'(1);
      end
      wdt_fire     = wdt_enable_in && drive_reg
                     && (wdt_cnt_reg >= wdt_limit);
      wdt_hit_next = wdt_fire;

      if (scl_fall) begin
         fell_next = 1'b1;
      end

      // ---------------------------------------------------------
      // bit engine
      // ---------------------------------------------------------
      case (state_reg)
         SITP_ADDR, SITP_REG, SITP_WDATA: begin
            if (scl_rise) begin
               shift_next  = {shift_reg[6:0], sda};
               bitcnt_next = bitcnt_reg + 3'h1;
               done_next   = (bitcnt_reg == SITP_LAST_BIT);
            end else if (scl_fall && done_reg) begin
               done_next   = 1'b0;
               bitcnt_next = 3'h0;
               if (state_reg == SITP_ADDR) begin
                  // 10-bit headers never match a 7-bit address
                  if (shift_reg[7:1] == own_addr) begin
                     rw_next    = shift_reg[SITP_RW_BIT];
                     drive_next = 1'b1;
                     state_next = SITP_ADDR_ACK;
                     if (shift_reg[SITP_RW_BIT]) begin
                        addr_next = base_reg;
                     end
                  end else begin
                     state_next = SITP_IGNORE;
                  end
               end else if (state_reg == SITP_REG) begin
                  base_next  = shift_reg;
                  addr_next  = shift_reg;
                  drive_next = 1'b1;
                  state_next = SITP_REG_ACK;
               end else begin
                  wdata_next = shift_reg;
                  write_next = 1'b1;
                  drive_next = 1'b1;
                  state_next = SITP_WDATA_ACK;
               end
            end
         end
         SITP_ADDR_ACK: begin
            // ack held low through the whole high phase
            if (scl_fall) begin
               if (rw_reg) begin
                  shift_next = reg_rdata_in;
                  read_next  = 1'b1;
                  addr_next  = addr_reg + 8'h01;
                  drive_next = ~reg_rdata_in[7];
                  state_next = SITP_RDATA;
               end else begin
                  drive_next = 1'b0;
                  state_next = SITP_REG;
               end
            end
         end
         SITP_REG_ACK: begin
            if (scl_fall) begin
               drive_next = 1'b0;
               state_next = SITP_WDATA;
            end
         end
         SITP_WDATA_ACK: begin
            if (scl_fall) begin
               drive_next = 1'b0;
               addr_next  = addr_reg + 8'h01;
               state_next = SITP_WDATA;
            end
         end
         SITP_RDATA: begin
            if (scl_rise) begin
               bitcnt_next = bitcnt_reg + 3'h1;
               done_next   = (bitcnt_reg == SITP_LAST_BIT);
            end else if (scl_fall) begin
               if (done_reg) begin
                  done_next   = 1'b0;
                  bitcnt_next = 3'h0;
                  drive_next  = 1'b0;
                  state_next  = SITP_RACK;
               end else begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  drive_next = ~shift_reg[6];
               end
            end
         end
         SITP_RACK: begin
            if (scl_rise) begin
               mack_next = ~sda;
            end else if (scl_fall) begin
               if (mack_reg) begin
                  shift_next = reg_rdata_in;
                  read_next  = 1'b1;
                  addr_next  = addr_reg + 8'h01;
                  drive_next = ~reg_rdata_in[7];
                  state_next = SITP_RDATA;
               end else begin
                  drive_next = 1'b0;
                  state_next = SITP_IGNORE;
               end
            end
         end
         default: begin
            drive_next = 1'b0;
         end
      endcase

      // ---------------------------------------------------------
      // bus conditions override the bit engine
      // ---------------------------------------------------------
      if (start_cond) begin
         busy_next   = 1'b1;
         fell_next   = 1'b0;
         state_next  = SITP_ADDR;
         bitcnt_next = 3'h0;
         done_next   = 1'b0;
         drive_next  = 1'b0;
         write_next  = 1'b0;
         read_next   = 1'b0;
      end else if (stop_cond && fell_reg) begin
         busy_next   = 1'b0;
         state_next  = SITP_IDLE;
         bitcnt_next = 3'h0;
         done_next   = 1'b0;
         drive_next  = 1'b0;
      end

      // a watchdog hit wins over everything but leaves the base pointer
      if (wdt_fire) begin
         state_next  = SITP_IDLE;
         busy_next   = 1'b0;
         bitcnt_next = 3'h0;
         done_next   = 1'b0;
         drive_next  = 1'b0;
         wdt_cnt_next = '0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg   <= SITP_IDLE;
         bitcnt_reg  <= 3'h0;
         done_reg    <= 1'b0;
         shift_reg   <= 8'h00;
         addr_reg    <= SITP_BASE_RST;
         base_reg    <= SITP_BASE_RST;
         rw_reg      <= 1'b0;
         mack_reg    <= 1'b0;
         fell_reg    <= 1'b0;
         busy_reg    <= 1'b0;
         drive_reg   <= 1'b0;
         write_reg   <= 1'b0;
         read_reg    <= 1'b0;
         wdata_reg   <= 8'h00;
         wdt_cnt_reg <= '0;
         wdt_hit_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         bitcnt_reg  <= bitcnt_next;
         done_reg    <= done_next;
         shift_reg   <= shift_next;
         addr_reg    <= addr_next;
         base_reg    <= base_next;
         rw_reg      <= rw_next;
         mack_reg    <= mack_next;
         fell_reg    <= fell_next;
         busy_reg    <= busy_next;
         drive_reg   <= drive_next;
         write_reg   <= write_next;
         read_reg    <= read_next;
         wdata_reg   <= wdata_next;
         wdt_cnt_reg <= wdt_cnt_next;
         wdt_hit_reg <= wdt_hit_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // open drain: the pad only ever pulls low
   always_comb begin
      serial_data_pin_out    = 1'b0;
      serial_data_pin_oe_out = drive_reg;
      reg_access_out.addr    = addr_reg;
      reg_access_out.wdata   = wdata_reg;
      reg_access_out.write   = write_reg;
      reg_access_out.read    = read_reg;
      bus_busy_out           = busy_reg;
      wdt_timeout_out        = wdt_hit_reg;
   end

endmodule

`default_nettype wire

// >>> hdl/sitp_pkg.sv
`default_nettype none
package sitp_pkg;

   // ------------------------------------------------------------
   // target addresses and reset values
   // ------------------------------------------------------------
   localparam logic [6:0] SITP_ADDR_STRAP_LOW  = 7'h18;
   localparam logic [6:0] SITP_ADDR_STRAP_HIGH = 7'h19;
   localparam logic [7:0] SITP_BASE_RST        = 8'h00;
   localparam int         SITP_RW_BIT          = 0;
   localparam logic [2:0] SITP_LAST_BIT        = 3'h7;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int SITP_CLK_PERIOD_NS  = 10;
   localparam int SITP_NS_PER_MS      = 1_000_000;
   localparam int SITP_NS_PER_US      = 1_000;
   localparam int SITP_WDT_SHORT_MS   = 1;
   localparam int SITP_WDT_LONG_MS    = 50;
   localparam int SITP_WDT_SHORT_CYC  =
      SITP_WDT_SHORT_MS * SITP_NS_PER_MS / SITP_CLK_PERIOD_NS;
   localparam int SITP_WDT_LONG_CYC   =
      SITP_WDT_LONG_MS * SITP_NS_PER_MS / SITP_CLK_PERIOD_NS;
   // idle gap the master keeps after a write (not enforced here)
   localparam int SITP_IDLE_NORM_US   = 2;
   localparam int SITP_IDLE_SUSP_US   = 450;
   localparam int SITP_IDLE_NORM_CYC  =
      (SITP_IDLE_NORM_US * SITP_NS_PER_US + SITP_CLK_PERIOD_NS - 1)
      / SITP_CLK_PERIOD_NS;
   localparam int SITP_IDLE_SUSP_CYC  =
      (SITP_IDLE_SUSP_US * SITP_NS_PER_US + SITP_CLK_PERIOD_NS - 1)
      / SITP_CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      SITP_IDLE      = 4'h0,
      SITP_ADDR      = 4'h1,
      SITP_ADDR_ACK  = 4'h3,
      SITP_REG       = 4'h2,
      SITP_REG_ACK   = 4'h6,
      SITP_WDATA     = 4'h7,
      SITP_WDATA_ACK = 4'h5,
      SITP_RDATA     = 4'h4,
      SITP_RACK      = 4'hC,
      SITP_IGNORE    = 4'hD
   } sitp_state_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       write;
      logic       read;
   } sitp_access_type;

endpackage
`default_nettype wire

// >>> verification/sitp_target_props.sv
`timescale 1ns/10ps
`default_nettype none
module sitp_props #(
   parameter int WDT_SHORT_CYCLES = sitp_pkg::SITP_WDT_SHORT_CYC,
   parameter int WDT_LONG_CYCLES  = sitp_pkg::SITP_WDT_LONG_CYC
) (
   input wire logic                      clk_sys_in,
   input wire logic                      rst_n_in,
   input wire logic                      serial_clock_pin_in,
   input wire logic                      serial_data_pin_in,
   input wire logic                      serial_data_pin_out,
   input wire logic                      serial_data_pin_oe_out,
   input wire logic                      wdt_enable_in,
   input wire logic                      wdt_long_period_in,
   input wire sitp_pkg::sitp_access_type reg_access_out,
   input wire logic                      bus_busy_out,
   input wire logic                      wdt_timeout_out
);
   import sitp_pkg::*;
   int hold_reg;
   int hold_next;
   // cycles the port pulls data while the clock sits low
   always_comb begin
      hold_next = (serial_data_pin_oe_out && !serial_clock_pin_in)
                ? hold_reg + 1 : 0;
   end
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) hold_reg <= 0;
      else hold_reg <= hold_next;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   a_open_drain: assert property (!serial_data_pin_out)
      else $error("data pin driven high");
   a_oe_steady: assert property (serial_clock_pin_in [*6]
      |-> $stable(serial_data_pin_oe_out)) else $error("data moved in high");
   a_busy_start: assert property ($fell(serial_data_pin_in)
      && serial_clock_pin_in |-> ##[2:6] bus_busy_out)
      else $error("start not seen");
   a_idle_release: assert property (!bus_busy_out
      |-> !serial_data_pin_oe_out) else $error("pulls data while idle");
   a_write_ack: assert property (reg_access_out.write
      |-> ##[0:1] serial_data_pin_oe_out) else $error("write not acked");
   a_read_incr: assert property (reg_access_out.read ##[100:200]
      reg_access_out.read |-> reg_access_out.addr
      == $past(reg_access_out.addr) + 8'h01) else $error("no increment");
   a_tmo_release: assert property (wdt_timeout_out |-> ##[0:1]
      (!serial_data_pin_oe_out && !bus_busy_out)) else $error("no release");
   a_tmo_single: assert property (wdt_timeout_out |=>
      !wdt_timeout_out) else $error("timeout not a pulse");
   a_wdt_off: assert property (!$past(wdt_enable_in)
      |-> !wdt_timeout_out) else $error("timeout while disabled");
   a_wdt_bound: assert property (wdt_enable_in |-> hold_reg <=
      (wdt_long_period_in ? WDT_LONG_CYCLES : WDT_SHORT_CYCLES) + 8)
      else $error("watchdog late");
endmodule
bind sitp_target sitp_props #(
   .WDT_SHORT_CYCLES(WDT_SHORT_CYCLES),
   .WDT_LONG_CYCLES (WDT_LONG_CYCLES)
) props (
   .clk_sys_in            (clk_sys_in),
   .rst_n_in              (rst_n_in),
   .serial_clock_pin_in   (serial_clock_pin_in),
   .serial_data_pin_in    (serial_data_pin_in),
   .serial_data_pin_out   (serial_data_pin_out),
   .serial_data_pin_oe_out(serial_data_pin_oe_out),
   .wdt_enable_in         (wdt_enable_in),
   .wdt_long_period_in    (wdt_long_period_in),
   .reg_access_out        (reg_access_out),
   .bus_busy_out          (bus_busy_out),
   .wdt_timeout_out       (wdt_timeout_out)
);
`default_nettype wire

// >>> verification/sitp_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module sitp_master_model (
   input  wire logic sda_in,
   output var logic  scl_out,
   output var logic  sda_oe_out
);
   logic [8:0] rx_val;
   event       rx_ev;
   // clock stands high between frames
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic start();
      #20 sda_oe_out = 1'b0;
      #40 scl_out = 1'b1;
      #40 sda_oe_out = 1'b1;
      #40 scl_out = 1'b0;
   endtask
   task automatic start_stop();
      sda_oe_out = 1'b1;
      #80 sda_oe_out = 1'b0;
      #80;
   endtask
   task automatic stop();
      sda_oe_out = 1'b1;
      #40 scl_out = 1'b1;
      #40 sda_oe_out = 1'b0;
      #80;
   endtask
   // stall stretches the ack clock low
   task automatic wr_byte(input logic [7:0] b, input int stall);
      for (int i = 7; i >= 0; i--) begin
         #20 sda_oe_out = ~b[i];
         #60 scl_out = 1'b1;
         #80 scl_out = 1'b0;
      end
      #20 sda_oe_out = 1'b0;
      #(60 + stall) scl_out = 1'b1;
      #40 rx_val = {1'b1, 7'h00, sda_in};
      #40 scl_out = 1'b0;
      ->rx_ev;
   endtask
   task automatic rd_byte(input logic nack);
      logic [7:0] b;
      #20 sda_oe_out = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #60 scl_out = 1'b1;
         #40 b[i] = sda_in;
         #40 scl_out = 1'b0;
         #20;
      end
      sda_oe_out = ~nack;
      #60 scl_out = 1'b1;
      #80 scl_out = 1'b0;
      rx_val = {1'b0, b};
      ->rx_ev;
   endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import sitp_pkg::*;
   logic            clk_sys_in;
   logic            rst_n_in;
   logic            strap;
   logic            wdt_en;
   logic            wdt_long;
   logic            scl;
   logic            m_oe;
   logic            d_out;
   logic            d_oe;
   logic            busy;
   logic            tmo;
   wire             sda;
   sitp_access_type acc;
   int              errors = 0;
   int              total_checks = 0;
   int              cycles = 0;
   int              tmo_cnt = 0;
   logic [15:0]     exp_wr[$];
   logic [8:0]      exp_rx[$];
   logic [15:0]     wr_exp;
   logic [15:0]     rx_exp;
   string           rx_name;
   // pull-up wins unless someone pulls low
   assign sda = ~(m_oe | (d_oe & ~d_out));
   sitp_master_model m (.sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
   sitp_target #(.WDT_SHORT_CYCLES(40), .WDT_LONG_CYCLES(200)) dut (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .serial_clock_pin_in(scl), .serial_data_pin_in(sda),
      .serial_data_pin_out(d_out), .serial_data_pin_oe_out(d_oe),
      .address_select_pin_in(strap), .wdt_enable_in(wdt_en),
      .wdt_long_period_in(wdt_long), .reg_rdata_in(acc.addr ^ 8'h5a),
      .reg_access_out(acc), .bus_busy_out(busy), .wdt_timeout_out(tmo));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict();
      chk("pending", 16'h0000, 16'(exp_wr.size() + exp_rx.size()));
      if (errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wb(logic [7:0] b, logic ack, int stall = 0);
      exp_rx.push_back({1'b1, 7'h00, ack});
      m.wr_byte(b, stall);
   endtask
   task automatic rb(logic nack, logic [7:0] e);
      exp_rx.push_back({1'b0, e});
      m.rd_byte(nack);
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // outputs looked at half a cycle after the edge that sets them
   always @(negedge clk_sys_in) begin
      cycles++;
      if (acc.write) begin
         wr_exp = exp_wr.size() ? exp_wr.pop_front() : 16'hxxxx;
         chk("write", wr_exp, {acc.addr, acc.wdata});
      end
      if (tmo) tmo_cnt++;
      if (cycles == 70000) begin
         chk("run time", 16'h0000, 16'h0001);
         give_verdict();
      end
   end
   always @(m.rx_ev) begin
      rx_name = m.rx_val[8] ? "ack" : "rdata";
      rx_exp = exp_rx.size() ? 16'(exp_rx.pop_front()) : 16'hxxxx;
      chk(rx_name, rx_exp, {7'h00, m.rx_val});
   end
   initial begin
      logic [7:0] r;
      logic [7:0] d;
      logic [6:0] ok;
      rst_n_in = 1'b0;
      strap = 1'b0;
      wdt_en = 1'b0;
      wdt_long = 1'b0;
      void'($urandom(63243));
      repeat (10) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (5) @(negedge clk_sys_in);
      chk("reset", 16'h0000, {6'h00, busy, d_oe, acc.addr});
      m.start();
      wb({SITP_ADDR_STRAP_LOW, 1'b1}, 1'b0);
      rb(1'b0, 8'h5a);
      rb(1'b1, 8'h5b);
      m.stop();
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys_in);
         strap <= s[0];
         ok = s[0] ? SITP_ADDR_STRAP_HIGH : SITP_ADDR_STRAP_LOW;
         r = 8'($urandom);
         d = 8'($urandom);
         @(negedge clk_sys_in);
         m.start();
         #100 chk("busy", 16'h0001, {15'h0000, busy});
         wb({ok, 1'b0}, 1'b0);
         wb(r, 1'b0);
         exp_wr.push_back({r, d});
         wb(d, 1'b0);
         m.stop();
         #100 chk("busy", 16'h0000, {15'h0000, busy});
         // second pass keeps the suspend-mode gap after its write
         #((s ? SITP_IDLE_SUSP_US : SITP_IDLE_NORM_US)
           * SITP_NS_PER_US);
         m.start();
         wb({ok ^ 7'h01, 1'b0}, 1'b1);
         wb(8'h00, 1'b1);
         m.stop();
         m.start();
         wb({ok, 1'b0}, 1'b0);
         wb(r, 1'b0);
         m.start();
         wb({ok, 1'b1}, 1'b0);
         for (int i = 0; i < 3; i++) rb(i == 2, (r + 8'(i)) ^ 8'h5a);
         m.stop();
         m.start();
         wb({ok, 1'b1}, 1'b0);
         rb(1'b1, r ^ 8'h5a);
         m.stop();
      end
      m.start_stop();
      chk("busy", 16'h0001, {15'h0000, busy});
      m.start();
      wb(8'hf0, 1'b1);
      m.stop();
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_sys_in);
         wdt_en <= (k < 2);
         wdt_long <= (k == 1);
         @(negedge clk_sys_in);
         m.start();
         wb({SITP_ADDR_STRAP_HIGH, 1'b0}, k == 0, 1000);
         m.stop();
         chk("timeouts", 16'h0001, 16'(tmo_cnt));
      end
      give_verdict();
   end
endmodule
`default_nettype wire
